/* File: test/core_model.sv */
// Core-side partner: takes an offered vector after a chosen delay.
// Assumes one clock; the bench plays software and clears the disable flag.
`timescale 1ns/100ps
module core_model (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire        intRequest,
	input  wire [15:0] vectorAddr,
	input  wire [1:0]  ackDelay,
	output reg         intAck,
	output reg  [15:0] takenVec,
	output reg  [7:0]  ackCount
);
	// Waits at least one cycle, since the vector register lags the grant
	initial begin
		intAck = 0;
		takenVec = 16'h0000;
		ackCount = 8'h00;
		forever begin
			@(posedge sys_clk);
			if (rst_n && intRequest) begin
				repeat (ackDelay) @(posedge sys_clk);
				#1 intAck = 1;
				takenVec = vectorAddr;
				@(posedge sys_clk);
				#1 intAck = 0;
				ackCount = ackCount + 8'h01;
			end
		end
	end
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the vectored interrupt unit.
// Assumes core_model answers vectors; the bench plays software and events.
`timescale 1ns/100ps
module testbench;
	reg         sys_clk = 0;
	reg         rst_n = 0;
	reg  [7:0]  regAddr = 8'hFE;
	reg  [7:0]  regWrData = 8'h00;
	reg         regWrite = 0;
	reg  [1:0]  pin = 2'h3;
	reg  [7:0]  ev = 8'h00;
	reg  [1:0]  ackDelay = 2'h1;
	wire [7:0]  regRdData, ackCount;
	wire [15:0] vectorAddr, takenVec;
	wire        intAck, intRequest, breakFlag, disableFlag, serialPortSelect;
	int         fail_count = 0, total_checks = 0, acks = 0, i, k, m;
	// --------
	// Design, partner and helpers
	// --------
	vectored_interrupt_unit i_vectored_interrupt_unit (
		.sys_clk, .rst_n, .regAddr, .regWrData, .regWrite, .regRdData,
		.extPinOne(pin[0]), .extPinTwo(pin[1]), .timerXZero(ev[0]), .timerOneZero(ev[1]),
		.timerTwoZero(ev[2]), .serialClkTick(ev[3]), .serialLoad(ev[4]),
		.breakInstruction(ev[5]), .setDisable(ev[6]), .clearDisable(ev[7]), .intAck,
		.intRequest, .vectorAddr, .breakFlag, .disableFlag, .serialPortSelect);
	core_model i_core_model (.sys_clk, .rst_n, .intRequest, .vectorAddr, .ackDelay,
		.intAck, .takenVec, .ackCount);
	always #2 sys_clk = ~sys_clk;
	task tick; @(posedge sys_clk); #1; endtask
	task chk(input string n, input [15:0] e, input [15:0] g);
		total_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task rdchk(input string n, input [7:0] a, input [7:0] e);
		regAddr = a;
		tick;
		chk(n, e, regRdData);
	endtask
	// A gap cycle follows so a second write never raises the strobe in the same step
	task wr(input [7:0] a, input [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrite = 1;
		tick;
		regWrite = 0;
		tick;
	endtask
	// A gap cycle follows so back-to-back pulses never collide
	task pulse(input [7:0] p);
		ev = p;
		tick;
		ev = 0;
		tick;
	endtask
	// Source 0 is external one; lower priority means a lower vector pair
	function [15:0] vecOf(input int s);
		vecOf = 16'hFFFC - 16'(2 * s);
	endfunction
	task take(input [15:0] e);
		acks++;
		ackDelay = 2'($urandom % 3 + 1);
		for (k = 0; k < 20 && ackCount != 8'(acks); k++) tick;
		chk("ackcount", 16'(acks), 16'(ackCount));
		chk("vector", e, takenVec);
		pulse(8'h80);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Whole run is a few hundred cycles; this margin only cuts a hang
	initial begin
		#100000;
		fail_count++;
		report_and_stop;
	end
	// --------
	// Scenarios
	// --------
	initial begin
		void'($urandom(84741));
		repeat (16) @(posedge sys_clk);
		#1 rst_n = 1;
		chk("disable", 1, disableFlag);
		rdchk("select", 8'hF6, 8'h00);
		rdchk("unmapped", 8'h10, 8'h00);
		rdchk("control", 8'hFE, 8'h00);
		take(16'hFFFE);
		wr(8'hFE, 8'hF0);
		for (i = 0; i < 4; i++) begin
			m = i ? $urandom % 7 + 1 : 7;
			pulse(8'h40);
			pulse(8'(m));
			chk("pending", 16'(m * 2), 16'(regRdData[3:0]));
			chk("blocked", 0, intRequest);
			pulse(8'h80);
			for (int s = 1; s < 4; s++) if (m[s - 1]) take(vecOf(s));
			chk("cleared", 0, 16'(regRdData[3:0]));
		end
		wr(8'hFE, 8'h0F);
		chk("swset", 0, 16'(regRdData[3:0]));
		pulse(8'h01);
		chk("masked", 0, intRequest);
		wr(8'hFE, 8'h0D);
		chk("swclear", 0, 16'(regRdData[3:0]));
		pulse(8'h01);
		wr(8'hFE, 8'h2F);
		take(vecOf(1));
		pulse(8'h40);
		for (i = 0; i < 4; i++) begin
			wr(8'hF6, {2'b00, {2{i[1]}}, 4'h0});
			pin[i[0]] = ~i[1];
			repeat (4) tick;
			wr(8'hFE, 8'h00);
			pin[i[0]] = i[1];
			repeat (4) tick;
			rdchk("edge", 8'hFE, i[0] ? 8'h80 : 8'h01);
			wr(8'hFE, 8'h00);
			rdchk("once", 8'hFE, 8'h00);
		end
		for (i = 0; i < 2; i++) begin
			wr(8'hF5, {2'b00, i[0], 5'h04});
			chk("portsel", 1, serialPortSelect);
			pulse(8'h14);
			for (k = 0; k < 8 * (i + 1); k++) begin
				rdchk("serial", 8'hFE, 8'h00);
				pulse(8'h08);
			end
			rdchk("serial", 8'hFE, 8'h08);
			wr(8'hFE, 8'h00);
		end
		// Ext two alone: its enable shares a bit with timer 1; rising edge mode is set
		wr(8'hFE, 8'h40);
		pin[1] = 0;
		repeat (4) tick;
		pin[1] = 1;
		repeat (4) tick;
		pulse(8'h80);
		take(16'hFFF4);
		rdchk("ext2clear", 8'hFE, 8'h50);
		// Break raises no offer of its own; the core reads the ext two vector directly
		ev = 8'h20;
		tick;
		chk("breakflag", 1, breakFlag);
		chk("breakvec", 16'hFFF4, vectorAddr);
		ev = 0;
		tick;
		// Reset again mid-run: the reset vector must come back with the flag still set
		rst_n = 0;
		repeat (2) tick;
		rst_n = 1;
		chk("resetreq", 1, intRequest);
		take(16'hFFFE);
		report_and_stop;
	end
endmodule

/* File: test/vectored_interrupt_unit_assertions.sv */
// Port-level timing checks for the vectored interrupt unit.
// Read-back checks apply only while regAddr selects the control register.
`timescale 1ns/100ps
module vectored_interrupt_unit_assertions (
	input wire        sys_clk,
	input wire        rst_n,
	input wire [7:0]  regAddr,
	input wire [7:0]  regWrData,
	input wire        regWrite,
	input wire [7:0]  regRdData,
	input wire        timerXZero,
	input wire        timerOneZero,
	input wire        breakInstruction,
	input wire        intAck,
	input wire        intRequest,
	input wire [15:0] vectorAddr,
	input wire        breakFlag,
	input wire        disableFlag,
	input wire        serialPortSelect
);
	// --------
	// Checks
	// --------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_RESET_VEC: assert property (
		$rose(rst_n) |-> intRequest && vectorAddr == 16'hFFFE) else $error("no reset vector");
	AST_ACK_DISABLES: assert property (
		intAck |=> disableFlag) else $error("ack left disable clear");
	AST_ACK_QUIET: assert property (
		intAck && !breakFlag && !breakInstruction |=> !intRequest) else $error("offer after ack");
	// Break is left out: its vector may stand while the flag is set
	AST_DIS_BLOCKS: assert property (
		disableFlag && !breakFlag && !breakInstruction && vectorAddr != 16'hFFFE |-> !intRequest)
		else $error("offer while disabled");
	AST_TIMERX_REQ: assert property (
		timerXZero |=> regAddr != 8'hFE || regRdData[1]) else $error("timer X request lost");
	AST_TIMER1_REQ: assert property (
		timerOneZero |=> regAddr != 8'hFE || regRdData[2]) else $error("timer 1 request lost");
	AST_NO_SW_SET: assert property (
		regAddr == 8'hFE && !regRdData[1] && !timerXZero |=> regAddr != 8'hFE || !regRdData[1])
		else $error("request set without event");
	AST_SER_SEL: assert property (
		regWrite && regAddr == 8'hF5 |=> serialPortSelect == ($past(regWrData[3:2]) == 2'b01))
		else $error("port select wrong");
	AST_BREAK_VEC: assert property (
		breakInstruction && vectorAddr != 16'hFFFE |=> breakFlag && vectorAddr == 16'hFFF4)
		else $error("break vector wrong");
endmodule
bind vectored_interrupt_unit vectored_interrupt_unit_assertions i_chk (
	.sys_clk, .rst_n, .regAddr, .regWrData, .regWrite, .regRdData, .timerXZero,
	.timerOneZero, .breakInstruction, .intAck, .intRequest, .vectorAddr, .breakFlag,
	.disableFlag, .serialPortSelect);

/* File: verilog/vectored_interrupt_unit.v */
// Vectored interrupt unit: request latching, fixed-priority arbitration and
// vector supply for an 8-bit microcomputer core.
// Assumes the core gives a one-cycle register write strobe (reads follow regAddr alone), one-cycle
// timer zero pulses and serial clock pulses, and an acknowledge pulse when it
// takes the offered vector. All inputs are synchronous except the two pins.
`timescale 1ns/100ps
`include "vectored_interrupt_unit_defines.vh"

module vectored_interrupt_unit (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire [7:0]  regAddr,
	input  wire [7:0]  regWrData,
	input  wire        regWrite,
	output reg  [7:0]  regRdData,
	input  wire        extPinOne,
	input  wire        extPinTwo,
	input  wire        timerXZero,
	input  wire        timerOneZero,
	input  wire        timerTwoZero,
	input  wire        serialClkTick,
	input  wire        serialLoad,
	input  wire        breakInstruction,
	input  wire        setDisable,
	input  wire        clearDisable,
	input  wire        intAck,
	output wire        intRequest,
	output reg  [15:0] vectorAddr,
	output reg         breakFlag,
	output wire        disableFlag,
	output wire        serialPortSelect
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [5:0]              serialMode_r;
	reg [7:0]              specialSel_r;
	reg [`NUM_SRC:0]       request_r;      // Bit 4 is external two
	reg [`NUM_SRC:0]       enable_r;
	reg                    disable_r;
	reg [1:0]              syncOne_r;
	reg [1:0]              syncTwo_r;
	reg                    lastOne_r;
	reg                    lastTwo_r;
	reg [`SER_CNT_W-1:0]   serCount_r;
	reg                    serBusy_r;
	reg                    resetPending_r;

	wire [1:0] sharedSel = serialMode_r[`SER_SEL_HI:`SER_SEL_LO];
	wire       serialOn  = (sharedSel == `SER_SEL_SERIAL);
	assign serialPortSelect = serialOn;
	assign disableFlag      = disable_r;

	// ----------------------------------------
	// Pin edge detection
	// ----------------------------------------
	// Second stage only is looked at, so a slow edge counts once
	wire edgeOne = specialSel_r[`SFS_EDGE_ONE] ? (syncOne_r[1] & ~lastOne_r)
	                                           : (~syncOne_r[1] & lastOne_r);
	wire edgeTwo = specialSel_r[`SFS_EDGE_TWO] ? (syncTwo_r[1] & ~lastTwo_r)
	                                           : (~syncTwo_r[1] & lastTwo_r);

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			syncOne_r <= 2'h0;
			syncTwo_r <= 2'h0;
			lastOne_r <= 1'b0;
			lastTwo_r <= 1'b0;
		end else begin
			syncOne_r <= {syncOne_r[0], extPinOne};
			syncTwo_r <= {syncTwo_r[0], extPinTwo};
			lastOne_r <= syncOne_r[1];
			lastTwo_r <= syncTwo_r[1];
		end
	end

	// ----------------------------------------
	// Serial transfer counter
	// ----------------------------------------
	// Counts transfer clocks from a load; word length picks 8 or 16
	wire serDone = serialOn & serBusy_r & serialClkTick & (serCount_r == 4'h0);

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			serCount_r <= 4'h0;
			serBusy_r  <= 1'b0;
		end else if (serialLoad) begin
			serCount_r <= serialMode_r[`SER_LEN_BIT] ? `SER_CNT_LONG : `SER_CNT_SHORT;
			serBusy_r  <= 1'b1;
		end else if (serBusy_r && serialClkTick) begin
			serCount_r <= serCount_r - 4'h1;
			if (serCount_r == 4'h0)
				serBusy_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	// Lowest index wins; reset is handled outside this mask
	wire [`NUM_SRC:0] eligible = request_r & enable_r & {(`NUM_SRC+1){~disable_r}};
	reg  [`NUM_SRC:0] grant;
	reg  [15:0]       grantVec;

	// Idle default is the ext two pair, so an empty grant still shows a legal vector
	always @* begin
		grant    = 5'h00;
		grantVec = `VEC_EXT_TWO;
		if (eligible[`SRC_EXT_ONE]) begin
			grant[`SRC_EXT_ONE] = 1'b1;
			grantVec = `VEC_EXT_ONE;
		end else if (eligible[`SRC_TIMER_X]) begin
			grant[`SRC_TIMER_X] = 1'b1;
			grantVec = `VEC_TIMER_X;
		end else if (eligible[`SRC_TIMER_ONE]) begin
			grant[`SRC_TIMER_ONE] = 1'b1;
			grantVec = `VEC_TIMER_ONE;
		end else if (eligible[`SRC_SHARED]) begin
			grant[`SRC_SHARED] = 1'b1;
			grantVec = `VEC_SHARED;
		end else if (eligible[`NUM_SRC]) begin
			grant[`NUM_SRC] = 1'b1;
		end
	end

	// Pending reset vector or any granted source; disable flag blocks only sources
	assign intRequest = resetPending_r | (|grant);

	// ----------------------------------------
	// Hardware events and software writes
	// ----------------------------------------
	wire [`NUM_SRC:0] hwSet;
	assign hwSet[`SRC_EXT_ONE]   = edgeOne;
	assign hwSet[`SRC_TIMER_X]   = timerXZero;
	assign hwSet[`SRC_TIMER_ONE] = timerOneZero;
	assign hwSet[`SRC_SHARED]    = serialOn ? serDone
	                             : ((sharedSel == `SER_SEL_TIMER2) & timerTwoZero);
	assign hwSet[`NUM_SRC]       = edgeTwo;

	wire wrIcr = regWrite & (regAddr == `ADDR_INT_CONTROL);
	wire [`NUM_SRC:0] ackClr = (intAck & ~resetPending_r) ? grant : 5'h00;

	// Interrupt control layout: requests in bits 4:0 would clash with enables,
	// so requests sit in 3:0 only for the four lower sources; ext two request
	// and enable sit in a packed view below. A write can only clear
	wire [`NUM_SRC:0] swKeep = wrIcr ? {regWrData[7], regWrData[3:0]} : 5'h1F;
	wire [`NUM_SRC:0] swEn   = {regWrData[6], regWrData[7:4]};

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			request_r      <= 5'h00;
			enable_r       <= 5'h00;
			disable_r      <= 1'b1;
			serialMode_r   <= 6'h00;
			specialSel_r   <= `RST_BYTE;
			resetPending_r <= 1'b1;  // Reset vector offered first, unmaskable
			breakFlag      <= 1'b0;
			vectorAddr     <= `VEC_RESET;
		end else begin
			// Set wins over clear for every request bit
			request_r <= (request_r & swKeep & ~ackClr) | hwSet;
			if (wrIcr)
				enable_r <= swEn;
			if (regWrite && regAddr == `ADDR_SERIAL_MODE)
				serialMode_r <= regWrData[5:0];
			if (regWrite && regAddr == `ADDR_SPECIAL_SEL)
				specialSel_r <= regWrData;
			// Disable flag: acceptance sets it, the core may set or clear it
			if (intAck || setDisable || breakInstruction)
				disable_r <= 1'b1;
			else if (clearDisable)
				disable_r <= 1'b0;
			if (intAck)
				resetPending_r <= 1'b0;
			// Vector held in a flop; break shares the ext two vector
			if (resetPending_r)
				vectorAddr <= `VEC_RESET;
			else if (breakInstruction)
				vectorAddr <= `VEC_EXT_TWO;
			else
				vectorAddr <= grantVec;
			if (breakInstruction)
				breakFlag <= 1'b1;
			else if (intAck)
				breakFlag <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read back
	// ----------------------------------------
	always @* begin
		case (regAddr)
			`ADDR_INT_CONTROL: regRdData = {request_r[`NUM_SRC], enable_r[`NUM_SRC],
			                               enable_r[3:2], request_r[3:0]};
			`ADDR_SERIAL_MODE: regRdData = {2'h0, serialMode_r};
			`ADDR_SPECIAL_SEL: regRdData = specialSel_r;
			default:           regRdData = `RST_BYTE;
		endcase
	end

endmodule

/* File: verilog/vectored_interrupt_unit_defines.vh */
// Constants for the vectored interrupt unit: register offsets, bit positions,
// vector addresses and reset values. Definitions only.
`ifndef VECTORED_INTERRUPT_UNIT_DEFINES_VH
`define VECTORED_INTERRUPT_UNIT_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_SERIAL_MODE   8'hF5
`define ADDR_SPECIAL_SEL   8'hF6
`define ADDR_INT_CONTROL   8'hFE

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SER_SEL_LO         2
`define SER_SEL_HI         3
`define SER_LEN_BIT        5
`define SFS_EDGE_ONE       4
`define SFS_EDGE_TWO       5
// Interrupt control: request bits 0..3, enable bits 4 above
`define ICR_EN_SHIFT       4
`define NUM_SRC            4

// ----------------------------------------
// Source indices (interrupt control order)
// ----------------------------------------
`define SRC_EXT_ONE        0
`define SRC_TIMER_X        1
`define SRC_TIMER_ONE      2
`define SRC_SHARED         3

// ----------------------------------------
// Vectors (low byte address of each pair)
// ----------------------------------------
`define VEC_RESET          16'hFFFE
`define VEC_EXT_ONE        16'hFFFC
`define VEC_TIMER_X        16'hFFFA
`define VEC_TIMER_ONE      16'hFFF8
`define VEC_SHARED         16'hFFF6
`define VEC_EXT_TWO        16'hFFF4

// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define RST_BYTE           8'h00
`define SER_SEL_TIMER2     2'h0
`define SER_SEL_SERIAL     2'h1
`define SER_CNT_W          4
`define SER_CNT_SHORT      4'h7
`define SER_CNT_LONG       4'hF

`endif
